/* hdl/remote_alias_and_mailbox_regs.sv */
// Remote alias slots 5 to 7, their remap targets and two message bytes.
`include "alias_regs_params.svh"

module remote_alias_and_mailbox_regs (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire alias_regs_pkg::reg_addr_t reg_addr,
  input  wire alias_regs_pkg::reg_byte_t reg_wdata,
  output      alias_regs_pkg::reg_byte_t reg_rdata,
  output      logic                     reg_hit,
  input  wire alias_regs_pkg::i2c_addr_t target_addr_slot5,
  input  wire alias_regs_pkg::i2c_addr_t target_addr_slot6,
  input  wire alias_regs_pkg::i2c_addr_t target_addr_slot7,
  input  wire logic                     xact_valid,
  input  wire alias_regs_pkg::i2c_addr_t xact_addr,
  output      logic                     fwd_valid,
  output      alias_regs_pkg::i2c_addr_t fwd_addr,
  output      alias_regs_pkg::i2c_addr_t alias_addr_slot5,
  output      alias_regs_pkg::i2c_addr_t alias_addr_slot6,
  output      alias_regs_pkg::i2c_addr_t alias_addr_slot7
);
  import alias_regs_pkg::*;

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic [2:0]  slot_match;

  // Returns the alias slot index for a register offset, or 3 when none.
  function automatic logic [1:0] alias_index(input reg_addr_t a);
    case (a)
      `OFS_ALIAS_SLOT5: alias_index = 2'h0;
      `OFS_ALIAS_SLOT6: alias_index = 2'h1;
      `OFS_ALIAS_SLOT7: alias_index = 2'h2;
      default:          alias_index = 2'h3;
    endcase
  endfunction : alias_index

  // A zero alias is how software parks a slot, so it must never match.
  genvar g;
  generate
    for (g = 0; g < `NUM_ALIAS_SLOTS; g++) begin : g_match
      assign slot_match[g] = (st_r.alias_r[g] != `RST_ALIAS) &&
                             (st_r.alias_r[g] == xact_addr);
    end
  endgenerate

  always_comb begin
    logic [1:0] idx;
    idx = alias_index(reg_addr);
    st_nxt = st_r;
    // Target addresses are owned by neighbouring registers; sample them each cycle.
    st_nxt.target_r[0] = target_addr_slot5;
    st_nxt.target_r[1] = target_addr_slot6;
    st_nxt.target_r[2] = target_addr_slot7;
    if (reg_wr) begin
      if (idx != 2'h3) begin
        st_nxt.alias_r[idx] = reg_wdata[`ALIAS_FIELD_MSB:`ALIAS_FIELD_LSB];
      end
      if (reg_addr == `OFS_MSG_A) begin
        st_nxt.msg_a_r = reg_wdata;
      end
      if (reg_addr == `OFS_MSG_B) begin
        st_nxt.msg_b_r = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (idx != 2'h3) begin
        st_nxt.rdata_r = {st_r.alias_r[idx], 1'b0};
      end else if (reg_addr == `OFS_MSG_A) begin
        st_nxt.rdata_r = st_r.msg_a_r;
      end else if (reg_addr == `OFS_MSG_B) begin
        st_nxt.rdata_r = st_r.msg_b_r;
      end else begin
        st_nxt.rdata_r = 8'h00;
      end
    end
    // The forward strobe is a one-cycle pulse; whatever matches no slot stays local.
    st_nxt.fwd_valid_r = 1'b0;
    if (xact_valid) begin
      // Lowest slot wins should software program two slots alike.
      if (slot_match[0]) begin
        st_nxt.fwd_valid_r = 1'b1;
        st_nxt.fwd_addr_r  = st_r.target_r[0];
      end else if (slot_match[1]) begin
        st_nxt.fwd_valid_r = 1'b1;
        st_nxt.fwd_addr_r  = st_r.target_r[1];
      end else if (slot_match[2]) begin
        st_nxt.fwd_valid_r = 1'b1;
        st_nxt.fwd_addr_r  = st_r.target_r[2];
      end
    end
  end

  // The reset branch loads only constants, so the asynchronous path stays a plain clear or preset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r.alias_r     <= {`NUM_ALIAS_SLOTS{`RST_ALIAS}};
      st_r.target_r    <= '0;
      st_r.msg_a_r     <= `RST_MSG_A;
      st_r.msg_b_r     <= `RST_MSG_B;
      st_r.rdata_r     <= 8'h00;
      st_r.fwd_valid_r <= 1'b0;
      st_r.fwd_addr_r  <= 7'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata        = st_r.rdata_r;
  assign reg_hit          = (alias_index(reg_addr) != 2'h3) ||
                            (reg_addr == `OFS_MSG_A) || (reg_addr == `OFS_MSG_B);
  assign fwd_valid        = st_r.fwd_valid_r;
  assign fwd_addr         = st_r.fwd_addr_r;
  assign alias_addr_slot5 = st_r.alias_r[0];
  assign alias_addr_slot6 = st_r.alias_r[1];
  assign alias_addr_slot7 = st_r.alias_r[2];

  sequence s_alias5_hit;
    xact_valid && slot_match[0];
  endsequence

  // Higher slots only win when every lower slot misses.
  sequence s_alias6_hit;
    xact_valid && slot_match[1] && !slot_match[0];
  endsequence

  sequence s_alias7_hit;
    xact_valid && slot_match[2] && slot_match[1:0] == 2'b00;
  endsequence

  sequence s_msg_a_wr;
    reg_wr && reg_addr == `OFS_MSG_A;
  endsequence

  sequence s_msg_a_rd;
    reg_rd && !reg_wr && reg_addr == `OFS_MSG_A;
  endsequence

  AST_ALIAS_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == `OFS_ALIAS_SLOT6) |=> alias_addr_slot6 == $past(reg_wdata[7:1]))
    else $error("Alias slot 6 did not take written bits 7 to 1.");

  AST_REMAP: assert property (@(posedge sys_clk) disable iff (rst)
    s_alias5_hit |=> fwd_valid && fwd_addr == $past(st_r.target_r[0]))
    else $error("Slot 5 hit not forwarded with its target address.");

  AST_ZERO_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    (xact_valid && xact_addr == 7'h00) |=> !fwd_valid)
    else $error("Zero address forwarded through a disabled slot.");

  AST_RESV_BIT: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && alias_index(reg_addr) != 2'h3) |=> reg_rdata[0] == 1'b0)
    else $error("Reserved alias bit 0 read as one.");

  AST_MSG_RW: assert property (@(posedge sys_clk) disable iff (rst)
    s_msg_a_wr ##1 s_msg_a_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Message byte A did not read back its written value.");

  AST_MSG_B_RST: assert property (@(posedge sys_clk)
    $fell(rst) |-> st_r.msg_b_r == `RST_MSG_B && st_r.msg_a_r == `RST_MSG_A)
    else $error("Message bytes left reset with wrong values.");

  AST_NO_MATCH: assert property (@(posedge sys_clk) disable iff (rst)
    (xact_valid && slot_match == 3'b000) |=> !fwd_valid)
    else $error("Unmatched address forwarded.");

  AST_FWD_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    !xact_valid |=> !fwd_valid)
    else $error("Forward pulse without a transaction.");

  AST_ALIAS5_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == `OFS_ALIAS_SLOT5) |=>
      alias_addr_slot5 == $past(reg_wdata[`ALIAS_FIELD_MSB:`ALIAS_FIELD_LSB]))
    else $error("Alias slot 5 did not take written bits 7 to 1.");

  AST_ALIAS7_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == `OFS_ALIAS_SLOT7) |=>
      alias_addr_slot7 == $past(reg_wdata[`ALIAS_FIELD_MSB:`ALIAS_FIELD_LSB]))
    else $error("Alias slot 7 did not take written bits 7 to 1.");

  AST_REMAP6: assert property (@(posedge sys_clk) disable iff (rst)
    s_alias6_hit |=> fwd_valid && fwd_addr == $past(st_r.target_r[1]))
    else $error("Slot 6 hit not forwarded with its target address.");

  AST_REMAP7: assert property (@(posedge sys_clk) disable iff (rst)
    s_alias7_hit |=> fwd_valid && fwd_addr == $past(st_r.target_r[2]))
    else $error("Slot 7 hit not forwarded with its target address.");

  AST_MSG_A_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    s_msg_a_wr |=> st_r.msg_a_r == $past(reg_wdata))
    else $error("Message byte A did not take its written value.");

  AST_MSG_B_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == `OFS_MSG_B) |=> st_r.msg_b_r == $past(reg_wdata))
    else $error("Message byte B did not take its written value.");

  // Message bytes may change only by an explicit write, never as a side effect.
  AST_MSG_A_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == `OFS_MSG_A) |=> $stable(st_r.msg_a_r))
    else $error("Message byte A changed without a write.");

  AST_MSG_B_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_wr && reg_addr == `OFS_MSG_B) |=> $stable(st_r.msg_b_r))
    else $error("Message byte B changed without a write.");

  AST_ALIAS5_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == `OFS_ALIAS_SLOT5) |=>
      reg_rdata == {$past(alias_addr_slot5), 1'b0})
    else $error("Alias slot 5 read back a wrong byte.");

  AST_ALIAS7_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == `OFS_ALIAS_SLOT7) |=>
      reg_rdata == {$past(alias_addr_slot7), 1'b0})
    else $error("Alias slot 7 read back a wrong byte.");

  AST_ALIAS_RST: assert property (@(posedge sys_clk)
    $fell(rst) |-> alias_addr_slot5 == `RST_ALIAS && alias_addr_slot6 == `RST_ALIAS &&
      alias_addr_slot7 == `RST_ALIAS)
    else $error("Alias slots left reset with a nonzero field.");
endmodule : remote_alias_and_mailbox_regs

/* hdl/alias_regs_params.svh */
// Register offsets, reset values and field positions of the alias and message bank.
`ifndef ALIAS_REGS_PARAMS_SVH
`define ALIAS_REGS_PARAMS_SVH
`define OFS_ALIAS_SLOT5   8'h15
`define OFS_ALIAS_SLOT6   8'h16
`define OFS_ALIAS_SLOT7   8'h17
`define OFS_MSG_A         8'h18
`define OFS_MSG_B         8'h19
`define RST_ALIAS         7'h00
`define RST_MSG_A         8'h00
`define RST_MSG_B         8'h01
`define ALIAS_FIELD_MSB   7
`define ALIAS_FIELD_LSB   1
`define NUM_ALIAS_SLOTS   3
`endif

/* hdl/alias_regs_pkg.sv */
// Types shared by the alias and message register bank.
package alias_regs_pkg;
  typedef logic [6:0] i2c_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
  typedef struct packed {
    i2c_addr_t [2:0] alias_r;
    i2c_addr_t [2:0] target_r;
    reg_byte_t       msg_a_r;
    reg_byte_t       msg_b_r;
    reg_byte_t       rdata_r;
    logic            fwd_valid_r;
    i2c_addr_t       fwd_addr_r;
  } bank_state_t;
endpackage : alias_regs_pkg

/* test/ctrl_model.sv */
// Local controller model that issues register bytes and incoming addresses.
module ctrl_model (
  input  wire logic                      sys_clk,
  output      logic                      reg_wr,
  output      logic                      reg_rd,
  output      alias_regs_pkg::reg_addr_t reg_addr,
  output      alias_regs_pkg::reg_byte_t reg_wdata,
  output      logic                      xact_valid,
  output      alias_regs_pkg::i2c_addr_t xact_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import alias_regs_pkg::*;
  initial begin
    {reg_wr, reg_rd, xact_valid} = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    xact_addr = 7'h00;
  end
  task automatic req(input logic w, r, v, input reg_addr_t a, input reg_byte_t d);
    @(posedge sys_clk);
    #1;
    {reg_wr, reg_rd, xact_valid} = {w, r, v};
    reg_addr = a;
    reg_wdata = d;
    xact_addr = d[6:0];
    @(posedge sys_clk);
    #1;
    {reg_wr, reg_rd, xact_valid} = 3'b000;
    // Released data shows the inverse so a stale byte is never mistaken for valid.
    reg_wdata = ~d;
    xact_addr = ~d[6:0];
  endtask : req
  // Write then read one byte on consecutive edges, the tightest order the bus allows.
  task automatic wr_rd(input reg_addr_t a, input reg_byte_t d);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_wdata = ~d;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
  endtask : wr_rd
endmodule : ctrl_model

/* test/remote_alias_and_mailbox_regs_tb.sv */
// Self-checking bench for the alias and message register bank.
module remote_alias_and_mailbox_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alias_regs_pkg::*;
  logic      sys_clk, rst, reg_wr, reg_rd, reg_hit, xact_valid, fwd_valid;
  reg_addr_t reg_addr;
  reg_byte_t reg_wdata, reg_rdata;
  i2c_addr_t target_addr_slot5, target_addr_slot6, target_addr_slot7, xact_addr, fwd_addr;
  i2c_addr_t alias_addr_slot5, alias_addr_slot6, alias_addr_slot7;
  int        fails = 0;
  int        n_compared = 0;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  ctrl_model i_ctrl_model (
    .sys_clk    (sys_clk),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .xact_valid (xact_valid),
    .xact_addr  (xact_addr)
  );
  remote_alias_and_mailbox_regs i_remote_alias_and_mailbox_regs (
    .sys_clk           (sys_clk),
    .rst               (rst),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .reg_hit           (reg_hit),
    .target_addr_slot5 (target_addr_slot5),
    .target_addr_slot6 (target_addr_slot6),
    .target_addr_slot7 (target_addr_slot7),
    .xact_valid        (xact_valid),
    .xact_addr         (xact_addr),
    .fwd_valid         (fwd_valid),
    .fwd_addr          (fwd_addr),
    .alias_addr_slot5  (alias_addr_slot5),
    .alias_addr_slot6  (alias_addr_slot6),
    .alias_addr_slot7  (alias_addr_slot7)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic rd(input reg_addr_t a, input reg_byte_t exp);
    i_ctrl_model.req(1'b0, 1'b1, 1'b0, a, 8'h00);
    check(reg_rdata, exp);
    check({7'h00, reg_hit}, {7'h00, (a >= 8'h15 && a <= 8'h19)});
  endtask : rd
  task automatic xact(input i2c_addr_t a, input logic v, input i2c_addr_t exp);
    i_ctrl_model.req(1'b0, 1'b0, 1'b1, 8'h00, {1'b0, a});
    check({7'h00, fwd_valid}, {7'h00, v});
    if (v) begin
      check({1'b0, fwd_addr}, {1'b0, exp});
    end
  endtask : xact
  task automatic test_reset_values;
    for (int i = 0; i < 3; i++) begin
      rd(8'h15 + 8'(i), 8'h00);
    end
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h01);
    rd(8'h1a, 8'h00);
  endtask : test_reset_values
  task automatic test_messages;
    i_ctrl_model.req(1'b1, 1'b0, 1'b0, 8'h18, 8'ha5);
    i_ctrl_model.req(1'b1, 1'b0, 1'b0, 8'h19, 8'h5a);
    rd(8'h18, 8'ha5);
    rd(8'h19, 8'h5a);
    // A read that meets a write in one cycle still returns the old byte.
    i_ctrl_model.req(1'b1, 1'b1, 1'b0, 8'h19, 8'h77);
    check(reg_rdata, 8'h5a);
    rd(8'h19, 8'h77);
    i_ctrl_model.wr_rd(8'h18, 8'h3c);
    check(reg_rdata, 8'h3c);
  endtask : test_messages
  task automatic test_alias_forward;
    for (int i = 0; i < 3; i++) begin
      i_ctrl_model.req(1'b1, 1'b0, 1'b0, 8'h15 + 8'(i), 8'h41 + 8'(2 * i));
      rd(8'h15 + 8'(i), 8'h40 + 8'(2 * i));
      xact(7'h20 + 7'(i), 1'b1, 7'h50 + 7'(i));
    end
    check({1'b0, alias_addr_slot5}, 8'h20);
    check({1'b0, alias_addr_slot6}, 8'h21);
    check({1'b0, alias_addr_slot7}, 8'h22);
  endtask : test_alias_forward
  task automatic test_disabled;
    // Bit 0 set alone leaves the field at zero, so slot 5 must go quiet.
    i_ctrl_model.req(1'b1, 1'b0, 1'b0, 8'h15, 8'h01);
    rd(8'h15, 8'h00);
    xact(7'h20, 1'b0, 7'h00);
    xact(7'h00, 1'b0, 7'h00);
    xact(7'h33, 1'b0, 7'h00);
  endtask : test_disabled
  task automatic test_reset_again;
    // A mid-run reset must undo every byte written so far.
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h01);
    rd(8'h16, 8'h00);
    check({1'b0, alias_addr_slot7}, 8'h00);
    xact(7'h21, 1'b0, 7'h00);
  endtask : test_reset_again
  initial begin
    rst = 1'b1;
    target_addr_slot5 = 7'h50;
    target_addr_slot6 = 7'h51;
    target_addr_slot7 = 7'h52;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    test_reset_values;
    test_messages;
    test_alias_forward;
    test_disabled;
    test_reset_again;
    test_done;
  end
  initial begin
    #20000;
    fails++;
    test_done;
  end
endmodule : remote_alias_and_mailbox_regs_tb
